// File: loop_status_pkg.sv
// constants for the loop status word bank
package loop_status_pkg;
  localparam int WORD_W = 16;
  localparam logic [7:0] FORMAT_WORD_OFFSET = 8'h11;
  localparam logic [7:0] FLAGS_WORD_OFFSET = 8'h12;
  localparam logic [7:0] CMD_WORD_OFFSET = 8'h02;
  localparam int CMD_SAVE_BIT = 15;
  localparam int DP3_LSB = 12;
  localparam int DP4_LSB = 8;
  localparam int ERR3_LSB = 4;
  localparam int ERR4_LSB = 0;
  localparam int SAVE_DONE_BIT = 15;
  localparam int SENSOR_FAULT_BIT = 14;
  localparam int FATAL_FAULT_BIT = 12;
  localparam int STANDBY_BIT = 11;
  localparam int TUNED_BIT = 10;
  localparam int SETTING_FAULT_BIT = 9;
  localparam int STOPPED_BIT = 8;
  localparam int OUTPUT_STATE_BIT = 4;
  localparam int AUTOTUNE_BIT = 3;
  localparam int ALARM_ONE_BIT = 1;
  localparam int ALARM_TWO_BIT = 0;
  localparam logic [15:0] PV_FAULT_MARK = 16'hCCCC;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam int FIELD_W = 4;
  localparam int SPARE_HI_BIT = 13;
  localparam int SPARE_MID_LSB = 5;
  localparam int SPARE_MID_W = 3;
  localparam int SPARE_LO_BIT = 2;
  localparam logic FLAG_OFF = 1'h0;
  localparam logic FLAG_ON = 1'h1;
  localparam logic [2:0] SPARE_MID_ZERO = 3'h0;
endpackage : loop_status_pkg

// File: loop_status_word_bank.sv
// status word bank for loops three and four
//
// Function
// (RL1) report 4-bit decimal selector: loop three bits 15-12, loop four 11-8
// (RL2) report setting error index: loop three bits 7-4, loop four 3-0
// (RL3) raise save-done at bit 15 when nonvolatile copy finishes
// (RL4) host starts loop three save via command word bit 15
// (RL5) clear save-done as soon as save request is seen
// (RL6) save-done low after power-up until a save completes
// (RL7) sensor fault bit 14 on absent, open or out-of-range sensor
// (RL8) fatal fault bit 12 on compensator failure or watchdog timeout
// (RL9) standby bit 11 while waiting for first refresh after start
// (RL10) tuned-constants bit 10 when autotune yields new constants
// (RL11) tuned-constants high until host sends constants back
// (RL12) setting fault bit 9 when any host setting is invalid
// (RL13) stopped bit 8 low while regulating, high while halted
// (RL14) output-state bit 4 follows control output
// (RL15) autotune-active bit 3 high while autotuning runs
// (RL16) alarm bits 1 and 0 high while temperature in alarm range
// (RL17) bits 13, 7-5 and 2 always read zero
// (RL18) sensor fault replaces process value with CCCC
// (RL19) sample all fields coherently, present all three words per refresh
`timescale 1ns/1ps
`default_nettype none
module loop_status_word_bank
  import loop_status_pkg::*;
#(
  parameter int W = WORD_W
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic REFRESH,
  input wire logic [W-1:0] HOST_CMD_WORD,
  input wire logic SAVE_FINISHED,
  input wire logic [3:0] DP_LOOP3,
  input wire logic [3:0] DP_LOOP4,
  input wire logic [3:0] ERR_INDEX_LOOP3,
  input wire logic [3:0] ERR_INDEX_LOOP4,
  input wire logic SENSOR_ABSENT,
  input wire logic SENSOR_OPEN,
  input wire logic TEMP_OUT_OF_RANGE,
  input wire logic CJC_FAILURE,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic TUNED_UPDATE,
  input wire logic CONSTANTS_SENT,
  input wire logic SETTING_INVALID,
  input wire logic REGULATING,
  input wire logic CONTROL_OUTPUT,
  input wire logic AUTOTUNE_RUNNING,
  input wire logic IN_ALARM_ONE,
  input wire logic IN_ALARM_TWO,
  input wire logic [W-1:0] PV_RAW,
  output logic [W-1:0] FORMAT_WORD,
  output logic [W-1:0] FLAGS_WORD,
  output logic [W-1:0] PV_WORD,
  output logic WORDS_VALID
);
  // sticky flags kept between refreshes
  logic save_done_reg;
  logic save_done_next;
  logic tuned_reg;
  logic tuned_next;
  logic standby_reg;
  logic standby_next;
  // snapshot registers seen by the host
  logic [W-1:0] format_reg;
  logic [W-1:0] format_next;
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;
  logic [W-1:0] pv_reg;
  logic [W-1:0] pv_next;
  logic valid_reg;
  logic valid_next;
  // decoded request and fault terms
  wire save_req;
  wire save_clear;
  wire save_set;
  wire tuned_set;
  wire tuned_clear;
  wire sensor_fault;
  wire fatal_fault;
  wire stopped;
  wire [W-1:0] format_now;
  wire [W-1:0] flags_now;
  wire [W-1:0] pv_now;

  // (RL4) host save request bit
  assign save_req = HOST_CMD_WORD[CMD_SAVE_BIT];
  // (RL5) request clears flag
  assign save_clear = save_req;
  // (RL3) completion sets flag
  // a completion seen while the request is still held is ignored
  assign save_set = SAVE_FINISHED & ~save_req;
  // (RL10) update sets flag
  assign tuned_set = TUNED_UPDATE;
  // (RL11) sent-back clears flag
  // a new update in the same cycle wins, so fresh constants are never hidden
  assign tuned_clear = CONSTANTS_SENT & ~TUNED_UPDATE;
  // (RL7) sensor fault sources
  assign sensor_fault = SENSOR_ABSENT | SENSOR_OPEN | TEMP_OUT_OF_RANGE;
  // (RL8) fatal fault sources
  assign fatal_fault = CJC_FAILURE | WATCHDOG_TIMEOUT;
  // (RL13) halted when not regulating
  assign stopped = ~REGULATING;

  // (RL5) request held keeps the flag low for the whole write
  assign save_done_next = save_clear ? FLAG_OFF : (save_set ? FLAG_ON : save_done_reg);
  // (RL11) set wins over clear
  assign tuned_next = tuned_set ? FLAG_ON : (tuned_clear ? FLAG_OFF : tuned_reg);
  // (RL9) first refresh ends standby
  // restart is only by reset; a later refresh cannot raise it again
  assign standby_next = REFRESH ? FLAG_OFF : standby_reg;

  // (RL1) decimal selectors
  assign format_now[DP3_LSB +: FIELD_W] = DP_LOOP3;
  assign format_now[DP4_LSB +: FIELD_W] = DP_LOOP4;
  // (RL2) error indices
  assign format_now[ERR3_LSB +: FIELD_W] = ERR_INDEX_LOOP3;
  assign format_now[ERR4_LSB +: FIELD_W] = ERR_INDEX_LOOP4;

  // (RL3) save-done at the top bit
  assign flags_now[SAVE_DONE_BIT] = save_done_reg;
  // (RL7) sensor fault
  assign flags_now[SENSOR_FAULT_BIT] = sensor_fault;
  // (RL17) spare high bit
  assign flags_now[SPARE_HI_BIT] = FLAG_OFF;
  // (RL8) fatal fault
  assign flags_now[FATAL_FAULT_BIT] = fatal_fault;
  // (RL9) standby
  assign flags_now[STANDBY_BIT] = standby_reg;
  // (RL10) tuned constants
  assign flags_now[TUNED_BIT] = tuned_reg;
  // (RL12) setting fault
  assign flags_now[SETTING_FAULT_BIT] = SETTING_INVALID;
  // (RL13) stopped
  assign flags_now[STOPPED_BIT] = stopped;
  // (RL17) spare middle bits
  assign flags_now[SPARE_MID_LSB +: SPARE_MID_W] = SPARE_MID_ZERO;
  // (RL14) output state
  assign flags_now[OUTPUT_STATE_BIT] = CONTROL_OUTPUT;
  // (RL15) autotune active
  assign flags_now[AUTOTUNE_BIT] = AUTOTUNE_RUNNING;
  // (RL17) spare low bit
  assign flags_now[SPARE_LO_BIT] = FLAG_OFF;
  // (RL16) alarm ranges
  assign flags_now[ALARM_ONE_BIT] = IN_ALARM_ONE;
  assign flags_now[ALARM_TWO_BIT] = IN_ALARM_TWO;

  // (RL18) fault marker on process value
  // the marker replaces the raw value so the host never acts on a bad reading
  assign pv_now = sensor_fault ? PV_FAULT_MARK : PV_RAW;

  // (RL19) coherent snapshot on refresh
  // all words take the same edge so the host never sees a torn pair
  assign format_next = REFRESH ? format_now : format_reg;
  assign flags_next = REFRESH ? flags_now : flags_reg;
  assign pv_next = REFRESH ? pv_now : pv_reg;
  assign valid_next = REFRESH | valid_reg;

  // (RL6) save-done low from reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      save_done_reg <= FLAG_OFF;
    end else begin
      save_done_reg <= save_done_next;
    end
  end

  // (RL11) tuned flag register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tuned_reg <= FLAG_OFF;
    end else begin
      tuned_reg <= tuned_next;
    end
  end

  // (RL9) standby set from reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      standby_reg <= FLAG_ON;
    end else begin
      standby_reg <= standby_next;
    end
  end

  // (RL1) format word snapshot
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      format_reg <= WORD_ZERO;
    end else begin
      format_reg <= format_next;
    end
  end

  // (RL19) flags word snapshot
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_reg <= WORD_ZERO;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // (RL18) process value snapshot
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pv_reg <= WORD_ZERO;
    end else begin
      pv_reg <= pv_next;
    end
  end

  // (RL19) words valid after first refresh
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      valid_reg <= FLAG_OFF;
    end else begin
      valid_reg <= valid_next;
    end
  end

  assign FORMAT_WORD = format_reg;
  assign FLAGS_WORD = flags_reg;
  assign PV_WORD = pv_reg;
  assign WORDS_VALID = valid_reg;
endmodule : loop_status_word_bank
`default_nettype wire

// File: loop_status_checker.sv
// assertions on the status word bank ports
`timescale 1ns/1ps
`default_nettype none
module loop_status_checker(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic REFRESH,
  input wire logic WORDS_VALID,
  input wire logic REGULATING,
  input wire logic SENSOR_ABSENT,
  input wire logic SENSOR_OPEN,
  input wire logic TEMP_OUT_OF_RANGE,
  input wire logic CJC_FAILURE,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic IN_ALARM_ONE,
  input wire logic IN_ALARM_TWO,
  input wire logic [15:0] HOST_CMD_WORD,
  input wire logic [15:0] PV_RAW,
  input wire logic [15:0] FLAGS_WORD,
  input wire logic [15:0] PV_WORD
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence save_seen;
    HOST_CMD_WORD[15] ##1 REFRESH;
  endsequence
  a_save_clear: assert property (save_seen |=> !FLAGS_WORD[15]) else $error("save");
  a_sensor_flag: assert property (REFRESH |=> FLAGS_WORD[14] ==
    $past(SENSOR_ABSENT | SENSOR_OPEN | TEMP_OUT_OF_RANGE)) else $error("sensor");
  a_fatal_flag: assert property (REFRESH |=> FLAGS_WORD[12] ==
    $past(CJC_FAILURE | WATCHDOG_TIMEOUT)) else $error("fatal");
  a_stop_flag: assert property (REFRESH |=>
    FLAGS_WORD[8] != $past(REGULATING)) else $error("stop");
  a_zero_bits: assert property ((FLAGS_WORD & 16'h20E4) == 16'h0000) else $error("zero");
  a_pv_mark: assert property (REFRESH |=> PV_WORD ==
    (FLAGS_WORD[14] ? 16'hCCCC : $past(PV_RAW))) else $error("pv");
  a_standby_clear: assert property (REFRESH && WORDS_VALID |=> !FLAGS_WORD[11])
    else $error("standby");
  a_alarm_flags: assert property (REFRESH |=> FLAGS_WORD[1:0] ==
    $past({IN_ALARM_ONE, IN_ALARM_TWO})) else $error("alarm");
  a_words_hold: assert property (!REFRESH |=> $stable(FLAGS_WORD)) else $error("hold");
  a_words_valid: assert property (REFRESH |=> WORDS_VALID) else $error("valid");
endmodule : loop_status_checker
bind loop_status_word_bank loop_status_checker loop_status_checker_i(.*);
`default_nettype wire

// File: host_refresh_model.sv
// host side: refresh strobe and command word
`timescale 1ns/1ps
`default_nettype none
module host_refresh_model(
  input wire logic poll, save,
  output logic refresh,
  output logic [15:0] cmd
);
  assign refresh = poll;
  assign cmd = {save, 15'h0000};
endmodule : host_refresh_model
`default_nettype wire

// File: loop_status_word_bank_bench.sv
// self-checking bench for the status word bank
`timescale 1ns/1ps
`default_nettype none
module loop_status_word_bank_bench;
  import loop_status_pkg::*;
  logic clk = 0, rstn = 0, poll = 0, save = 0, sd = 0, tn = 0, sb = 1, refresh, vw;
  logic [10:0] b = 0;
  logic [2:0] ev = 0;
  logic [15:0] fm = 16'h1A2B, pv = 16'h0123, cmd, fw, gw, pw;
  int failures = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  host_refresh_model host_refresh_model_i(.poll(poll), .save(save), .refresh(refresh), .cmd(cmd));
  loop_status_word_bank loop_status_word_bank_i(.CORE_CLK(clk), .RESETN(rstn), .REFRESH(refresh),
    .HOST_CMD_WORD(cmd), .SAVE_FINISHED(ev[0]), .DP_LOOP3(fm[15:12]), .DP_LOOP4(fm[11:8]),
    .ERR_INDEX_LOOP3(fm[7:4]), .ERR_INDEX_LOOP4(fm[3:0]), .SENSOR_ABSENT(b[0]),
    .SENSOR_OPEN(b[1]), .TEMP_OUT_OF_RANGE(b[2]), .CJC_FAILURE(b[3]), .WATCHDOG_TIMEOUT(b[4]),
    .TUNED_UPDATE(ev[2]), .CONSTANTS_SENT(ev[1]), .SETTING_INVALID(b[5]), .REGULATING(b[6]),
    .CONTROL_OUTPUT(b[7]), .AUTOTUNE_RUNNING(b[8]), .IN_ALARM_ONE(b[9]), .IN_ALARM_TWO(b[10]),
    .PV_RAW(pv), .FORMAT_WORD(fw), .FLAGS_WORD(gw), .PV_WORD(pw), .WORDS_VALID(vw));
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %0t word mismatch", $time);
    end
  endtask : chk
  task give_verdict;
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // pulses land one cycle before the refresh, so flags are settled when snapshotted
  task step(input logic [10:0] nb, input logic [2:0] e, input logic rq);
    @(negedge clk) b = nb;
    {ev, save, fm, pv} = {e, rq, fm + 16'h1111, pv + 16'h0F0F};
    if (e[2]) tn = 1; else if (e[1]) tn = 0;
    if (rq) sd = 0; else if (e[0]) sd = 1;
    @(negedge clk) ev = 0;
    poll = 1;
    @(negedge clk) poll = 0;
    chk(fw, fm);
    chk(gw, {sd, |nb[2:0], 1'b0, |nb[4:3], sb, tn, nb[5], ~nb[6], 3'h0, nb[7], nb[8], 1'b0,
      nb[9], nb[10]});
    chk(pw, |nb[2:0] ? PV_FAULT_MARK : pv);
    chk({15'h0000, vw}, 16'h0001);
    sb = 0;
  endtask : step
  initial begin
    repeat (16) @(negedge clk);
    chk(gw, WORD_ZERO);
    rstn = 1;
    step(0, 0, 0);
    for (int i = 0; i < 11; i++) step(11'(1 << i), 0, 0);
    step(0, 4, 0);
    step(0, 2, 0);
    step(0, 6, 0);
    step(0, 1, 0);
    step(0, 1, 1);
    step(0, 1, 0);
    give_verdict;
  end
endmodule : loop_status_word_bank_bench
`default_nettype wire
